// File: design/rasm_pkg.sv
// Constants for the register access cell bank.
// Assumes a single core clock and one access request per cycle.
package rasm_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 2;
    localparam int FLD_W  = 4;
    localparam int LOCK_W = 2;

    // Word addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_CELL = 2'h1;

    // Switch control register layout
    localparam int UNLOCK_BIT = 0;

    // Cell word layout
    localparam int HWI_LSB   = 0;
    localparam int RDCLR_LSB   = 4;
    localparam int RDCLRWR_LSB = 8;
    localparam int CONST_LSB = 12;
    localparam int STAT_LSB  = 16;
    localparam int RW_LSB    = 20;
    localparam int W1C_LSB   = 24;
    localparam int LOCK_LSB  = 28;
    localparam int ZERO_BIT  = 30;
    localparam int RSVD_BIT  = 31;

    // Reset and fixed values
    localparam logic [FLD_W-1:0]  FLD_RST    = 4'h0;
    localparam logic [LOCK_W-1:0] LOCK_RST   = 2'h0;
    localparam logic              UNLOCK_RST = 1'b0;
    localparam logic [FLD_W-1:0]  CONST_VAL  = 4'hA;

    typedef enum logic [1:0] {
        RASM_SRC_CFG,
        RASM_SRC_SMB,
        RASM_SRC_EEP
    } rasm_src_t;

    typedef enum logic {
        RASM_ST_STRAP,
        RASM_ST_RUN
    } rasm_phase_t;
endpackage

// File: design/rasm_bank.sv
// Register cell bank showing every software access type.
// Assumes the access sources are already merged onto one request port.
`timescale 1ns/1ns

// How it works
// - Same behaviour for config, serial, eeprom writes, except init bits (eeprom only)
// - Init bits from straps/eeprom, then read-only
// - Read-clear bits return value, then zero
// - Writes to read-clear bits are ignored
// - Read-clear-writable clears on read, takes writes
// - Hardwired constant reads fixed, ignores writes
// - Status bits follow hardware, writes ignored
// - Read/write bits store and return writes
// - Write-one-to-clear: zero keeps, one clears
// - Only hardware sets, only software clears
// - Lock-guarded bits written only when unlocked
// - Locked writes discarded, reads still work
// - Zero-type bits always read zero
module rasm_bank
(
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    // Access request
    input  wire logic                      accReq,
    input  wire logic                      accWrite,
    input  wire rasm_pkg::rasm_src_t       accSrc,
    input  wire logic [rasm_pkg::ADDR_W-1:0] accAddr,
    input  wire logic [rasm_pkg::DATA_W-1:0] accWdata,
    // Access answer
    output logic                           accAck,
    output logic [rasm_pkg::DATA_W-1:0]    accRdata,
    // Hardware side
    input  wire logic [rasm_pkg::FLD_W-1:0] strapIn,
    input  wire logic                      eepromDone,
    input  wire logic [rasm_pkg::FLD_W-1:0] rdClrEvent,
    input  wire logic [rasm_pkg::FLD_W-1:0] rdClrWrEvent,
    input  wire logic [rasm_pkg::FLD_W-1:0] w1cEvent,
    input  wire logic [rasm_pkg::FLD_W-1:0] statusIn,
    // Core view
    output logic [rasm_pkg::DATA_W-1:0]    cellWord,
    output logic                           unlockOut
);
    import rasm_pkg::*;

    function automatic logic [DATA_W-1:0] packWord(
        input logic [FLD_W-1:0]  hwi,
        input logic [FLD_W-1:0]  rdClr,
        input logic [FLD_W-1:0]  rdClrWr,
        input logic [FLD_W-1:0]  stat,
        input logic [FLD_W-1:0]  rw,
        input logic [FLD_W-1:0]  w1c,
        input logic [LOCK_W-1:0] lock);
        logic [DATA_W-1:0] w;
        w = '0;
        w[HWI_LSB +: FLD_W]    = hwi;
        w[RDCLR_LSB +: FLD_W]   = rdClr;
        w[RDCLRWR_LSB +: FLD_W] = rdClrWr;
        w[CONST_LSB +: FLD_W]  = CONST_VAL;
        w[STAT_LSB +: FLD_W]   = stat;
        w[RW_LSB +: FLD_W]     = rw;
        w[W1C_LSB +: FLD_W]    = w1c;
        w[LOCK_LSB +: LOCK_W]  = lock;
        // Zero and reserved bits stay zero from the clear above
        return w;
    endfunction

    rasm_phase_t       phase;
    rasm_phase_t       next_phase;
    logic [FLD_W-1:0]  hardware_initialized;
    logic [FLD_W-1:0]  next_hardware_initialized;
    logic [FLD_W-1:0]  rdClrBits;
    logic [FLD_W-1:0]  next_rdClrBits;
    logic [FLD_W-1:0]  rdClrWrBits;
    logic [FLD_W-1:0]  next_rdClrWrBits;
    logic [FLD_W-1:0]  statBits;
    logic [FLD_W-1:0]  next_statBits;
    logic [FLD_W-1:0]  rwBits;
    logic [FLD_W-1:0]  next_rwBits;
    logic [FLD_W-1:0]  w1cBits;
    logic [FLD_W-1:0]  next_w1cBits;
    logic [LOCK_W-1:0] lockBits;
    logic [LOCK_W-1:0] next_lockBits;
    logic              unlock;
    logic              next_unlock;
    logic              next_accAck;
    logic [DATA_W-1:0] next_accRdata;
    logic [DATA_W-1:0] next_cellWord;
    logic              wrCell;
    logic              rdCell;
    logic              wrCtrl;
    logic              rdCtrl;
    logic              eepInit;

    // Access source plays no part in address decode, only in eepInit
    assign wrCell  = accReq && accWrite && (accAddr == ADDR_CELL);
    assign rdCell  = accReq && !accWrite && (accAddr == ADDR_CELL);
    assign wrCtrl  = accReq && accWrite && (accAddr == ADDR_CTRL);
    assign rdCtrl  = accReq && !accWrite && (accAddr == ADDR_CTRL);
    assign eepInit = wrCell && (accSrc == RASM_SRC_EEP) && !eepromDone;

    always_comb
    begin
        next_phase   = RASM_ST_RUN;
        next_hardware_initialized  = hardware_initialized;
        case (phase)
            RASM_ST_STRAP:
            begin
                next_hardware_initialized = strapIn;
            end
            RASM_ST_RUN:
            begin
                // Only the eeprom loader may touch these, and only while eepromDone is low
                if (eepInit)
                begin
                    next_hardware_initialized = accWdata[HWI_LSB +: FLD_W];
                end
            end
            default:
            begin
                next_hardware_initialized = hardware_initialized;
            end
        endcase
        // Event in the read cycle survives the clear
        next_rdClrBits = (rdCell ? FLD_RST : rdClrBits)
                         | rdClrEvent;
        if (wrCell)
        begin
            next_rdClrWrBits = accWdata[RDCLRWR_LSB +: FLD_W]
                               | rdClrWrEvent;
        end
        else
        begin
            next_rdClrWrBits = (rdCell ? FLD_RST : rdClrWrBits)
                               | rdClrWrEvent;
        end
        next_statBits = statusIn;
        next_rwBits   = wrCell ? accWdata[RW_LSB +: FLD_W] : rwBits;
        // Set wins over a clear in the same cycle
        next_w1cBits  = (w1cBits & ~(wrCell ? accWdata[W1C_LSB +: FLD_W]
                                            : FLD_RST)) | w1cEvent;
        next_lockBits = (wrCell && unlock) ? accWdata[LOCK_LSB +: LOCK_W]
                                           : lockBits;
        next_unlock   = wrCtrl ? accWdata[UNLOCK_BIT] : unlock;
        next_accAck   = accReq;
        next_accRdata = '0;
        if (rdCell)
        begin
            next_accRdata = packWord(hardware_initialized, rdClrBits, rdClrWrBits, statBits,
                                     rwBits, w1cBits, lockBits);
        end
        else if (rdCtrl)
        begin
            next_accRdata[UNLOCK_BIT] = unlock;
        end
        next_cellWord = packWord(next_hardware_initialized, next_rdClrBits,
                                 next_rdClrWrBits, next_statBits,
                                 next_rwBits, next_w1cBits, next_lockBits);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            phase     <= RASM_ST_STRAP;
            hardware_initialized    <= FLD_RST;
            rdClrBits   <= FLD_RST;
            rdClrWrBits <= FLD_RST;
            statBits  <= FLD_RST;
            rwBits    <= FLD_RST;
            w1cBits   <= FLD_RST;
            lockBits  <= LOCK_RST;
            unlock    <= UNLOCK_RST;
            accAck    <= 1'b0;
            accRdata  <= '0;
            cellWord  <= '0;
            unlockOut <= UNLOCK_RST;
        end
        else
        begin
            phase     <= next_phase;
            hardware_initialized    <= next_hardware_initialized;
            rdClrBits   <= next_rdClrBits;
            rdClrWrBits <= next_rdClrWrBits;
            statBits  <= next_statBits;
            rwBits    <= next_rwBits;
            w1cBits   <= next_w1cBits;
            lockBits  <= next_lockBits;
            unlock    <= next_unlock;
            accAck    <= next_accAck;
            accRdata  <= next_accRdata;
            cellWord  <= next_cellWord;
            unlockOut <= next_unlock;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence cellWriteSeq;
        wrCell;
    endsequence

    // Write, a cycle with no write, then a read of the same word
    sequence cellWriteThenRead;
        wrCell ##1 !wrCell ##1 rdCell;
    endsequence

    AST_INIT_FROZEN: assert property (
        (phase == RASM_ST_RUN) && !eepInit |=> $stable(hardware_initialized))
        else $error("init bits changed after initialisation");

    AST_RDCLR_CLEAR: assert property (
        rdCell |=> rdClrBits == $past(rdClrEvent))
        else $error("read-clear bits not cleared by read");

    AST_RDCLR_WRITE_IGNORED: assert property (
        cellWriteSeq |=> rdClrBits == ($past(rdClrBits) | $past(rdClrEvent)))
        else $error("write changed read-clear bits");

    AST_RDCLRWR_WRITE: assert property (
        cellWriteSeq |=> rdClrWrBits ==
            ($past(accWdata[RDCLRWR_LSB +: FLD_W]) | $past(rdClrWrEvent)))
        else $error("read-clear-writable bits missed write");

    AST_RDCLRWR_READ: assert property (
        rdCell |=> rdClrWrBits == $past(rdClrWrEvent))
        else $error("read-clear-writable bits not cleared");

    AST_FIXED_FIELDS: assert property (
        rdCell |=> accAck && accRdata[CONST_LSB +: FLD_W] == CONST_VAL
                   && accRdata[ZERO_BIT] == 1'b0
                   && accRdata[RSVD_BIT] == 1'b0)
        else $error("constant, zero or reserved bits read wrong");

    AST_STATUS_FOLLOWS: assert property (
        1'b1 |=> cellWord[STAT_LSB +: FLD_W] == $past(statusIn))
        else $error("status bits do not follow hardware");

    AST_RW_READBACK: assert property (
        cellWriteThenRead |=> accRdata[RW_LSB +: FLD_W]
                              == $past(accWdata[RW_LSB +: FLD_W], 3))
        else $error("read/write bits read back wrong");

    AST_W1C_CLEAR: assert property (
        cellWriteSeq |=> (w1cBits & $past(accWdata[W1C_LSB +: FLD_W]))
            == ($past(w1cEvent) & $past(accWdata[W1C_LSB +: FLD_W])))
        else $error("write of one did not clear");

    AST_W1C_HOLD: assert property (
        !wrCell |=> (w1cBits & $past(w1cBits)) == $past(w1cBits))
        else $error("hardware cleared a write-one-to-clear bit");

    AST_LOCK_OPEN: assert property (
        cellWriteSeq and unlock |=>
            lockBits == $past(accWdata[LOCK_LSB +: LOCK_W]))
        else $error("unlocked write not taken");

    AST_LOCK_SHUT: assert property (
        wrCell && !unlock |=> $stable(lockBits))
        else $error("locked write changed guarded bits");
endmodule

// File: bench/rasm_host.sv
// Host software model driving the merged access port of the cell bank.
// Assumes the bench calls its tasks from one process, one at a time.
`timescale 1ns/1ns
module rasm_host
(
    // Clock
    input  wire logic                        core_clk,
    // Request
    output logic                             accReq,
    output logic                             accWrite,
    output rasm_pkg::rasm_src_t              accSrc,
    output logic [rasm_pkg::ADDR_W-1:0]      accAddr,
    output logic [rasm_pkg::DATA_W-1:0]      accWdata,
    // Answer
    input  wire logic                        accAck,
    input  wire logic [rasm_pkg::DATA_W-1:0] accRdata
);
    import rasm_pkg::*;

    initial
    begin
        accReq   = 1'b0;
        accWrite = 1'b0;
        accSrc   = RASM_SRC_CFG;
        accAddr  = 2'h3;
        accWdata = 32'h5A5A5A5A;
    end

    // Reserved bit may read anything, so never trust it
    function automatic logic [DATA_W-1:0] usable(input logic [DATA_W-1:0] w);
        return w & ~(32'h1 << RSVD_BIT);
    endfunction

    // One request cycle, then a bounded wait for the answer
    task automatic xfer(input logic w, input rasm_src_t s,
        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
        output logic [DATA_W-1:0] q, output logic ok);
        int n;
        @(negedge core_clk);
        accReq   = 1'b1;
        accWrite = w;
        accSrc   = s;
        accAddr  = a;
        accWdata = d & ~(32'h1 << ZERO_BIT);
        @(negedge core_clk);
        accReq   = 1'b0;
        accWdata = ~accWdata;
        // Answer stands only from this edge to the next one
        ok = (accAck === 1'b1);
        q  = ok ? accRdata : 32'h0;
        for (n = 0; n < 3 && !ok; n++)
        begin
            @(negedge core_clk);
            if (accAck === 1'b1)
            begin
                ok = 1'b1;
                q  = accRdata;
            end
        end
    endtask
endmodule

// File: bench/register_access_semantics_tb_top.sv
// Self-checking bench for the register access cell bank.
// Assumes inputs change on the falling edge, sampled on the rising one.
`timescale 1ns/1ns
module register_access_semantics_tb_top;
    import rasm_pkg::*;
    logic              core_clk, rst, accReq, accWrite, accAck;
    logic              eepromDone, unlockOut, ok;
    rasm_src_t         accSrc;
    logic [ADDR_W-1:0] accAddr;
    logic [DATA_W-1:0] accWdata, accRdata, cellWord, q;
    logic [FLD_W-1:0]  strapIn, rdClrEvent, rdClrWrEvent, w1cEvent;
    logic [FLD_W-1:0]  statusIn;
    int                mismatches, total_checks;

    rasm_bank i_rasm_bank (.core_clk(core_clk), .rst(rst),
        .accReq(accReq), .accWrite(accWrite), .accSrc(accSrc),
        .accAddr(accAddr), .accWdata(accWdata), .accAck(accAck),
        .accRdata(accRdata), .strapIn(strapIn), .eepromDone(eepromDone),
        .rdClrEvent(rdClrEvent), .rdClrWrEvent(rdClrWrEvent),
        .w1cEvent(w1cEvent),
        .statusIn(statusIn), .cellWord(cellWord), .unlockOut(unlockOut));
    rasm_host i_rasm_host (.core_clk(core_clk), .accReq(accReq),
        .accWrite(accWrite), .accSrc(accSrc), .accAddr(accAddr),
        .accWdata(accWdata), .accAck(accAck), .accRdata(accRdata));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch at %0t exp %h got %h", $time, e, g);
        end
    endtask

    // A lost answer leaves nothing further worth checking
    task automatic acc(input logic w, input rasm_src_t s,
        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        i_rasm_host.xfer(w, s, a, d, q, ok);
        if (ok !== 1'b1)
        begin
            mismatches++;
            give_verdict();
        end
    endtask

    function automatic logic [DATA_W-1:0] fl(input logic [DATA_W-1:0] w,
        input int lsb);
        return (w >> lsb) & 32'hF;
    endfunction

    task automatic t_reset;
        chk(32'h0000A005, cellWord);
        chk(32'h0, {31'h0, unlockOut});
        acc(1'b0, RASM_SRC_CFG, ADDR_CELL, 32'h0);
        chk(32'h0000A005, i_rasm_host.usable(q));
        acc(1'b0, RASM_SRC_CFG, 2'h2, 32'h0);
        chk(32'h0, q);
        $display("test reset done");
    endtask

    task automatic t_hardware_initialized;
        acc(1'b1, RASM_SRC_CFG, ADDR_CELL, 32'h3);
        chk(32'h5, fl(cellWord, HWI_LSB));
        acc(1'b1, RASM_SRC_EEP, ADDR_CELL, 32'h9);
        chk(32'h9, fl(cellWord, HWI_LSB));
        eepromDone = 1'b1;
        acc(1'b1, RASM_SRC_EEP, ADDR_CELL, 32'h00500006);
        chk(32'h9, fl(cellWord, HWI_LSB));
        chk(32'h5, fl(cellWord, RW_LSB));
        acc(1'b1, RASM_SRC_SMB, ADDR_CELL, 32'h00300000);
        chk(32'h3, fl(cellWord, RW_LSB));
        $display("test hardware_initialized done");
    endtask

    task automatic t_rdclr;
        rdClrEvent   = 4'h3;
        rdClrWrEvent = 4'h8;
        @(negedge core_clk);
        rdClrEvent   = 4'h0;
        rdClrWrEvent = 4'h0;
        chk(32'h3, fl(cellWord, RDCLR_LSB));
        chk(32'h8, fl(cellWord, RDCLRWR_LSB));
        acc(1'b1, RASM_SRC_CFG, ADDR_CELL, 32'h00000600);
        chk(32'h3, fl(cellWord, RDCLR_LSB));
        chk(32'h6, fl(cellWord, RDCLRWR_LSB));
        acc(1'b0, RASM_SRC_SMB, ADDR_CELL, 32'h0);
        chk(32'h3, fl(q, RDCLR_LSB));
        chk(32'h6, fl(q, RDCLRWR_LSB));
        chk(32'h0, fl(cellWord, RDCLR_LSB));
        chk(32'h0, fl(cellWord, RDCLRWR_LSB));
        acc(1'b0, RASM_SRC_CFG, ADDR_CELL, 32'h0);
        chk(32'h0, fl(q, RDCLR_LSB));
        chk(32'h0, fl(q, RDCLRWR_LSB));
        $display("test read clear done");
    endtask

    task automatic t_w1c;
        w1cEvent = 4'hF;
        @(negedge core_clk);
        w1cEvent = 4'h0;
        repeat (3) @(negedge core_clk);
        chk(32'hF, fl(cellWord, W1C_LSB));
        acc(1'b1, RASM_SRC_CFG, ADDR_CELL, 32'h05000000);
        chk(32'hA, fl(cellWord, W1C_LSB));
        acc(1'b1, RASM_SRC_EEP, ADDR_CELL, 32'h0);
        chk(32'hA, fl(cellWord, W1C_LSB));
        $display("test write one clear done");
    endtask

    task automatic t_fixed;
        statusIn = 4'h9;
        acc(1'b1, RASM_SRC_CFG, ADDR_CELL, 32'hFFFFFFFF);
        chk(32'hA, fl(cellWord, CONST_LSB));
        chk(32'h9, fl(cellWord, STAT_LSB));
        chk(32'hF, fl(cellWord, RW_LSB));
        chk(32'h0, cellWord >> LOCK_LSB);
        statusIn = 4'h2;
        repeat (2) @(negedge core_clk);
        chk(32'h2, fl(cellWord, STAT_LSB));
        $display("test fixed fields done");
    endtask

    task automatic t_lock(input logic v, input logic [DATA_W-1:0] d,
        input logic [DATA_W-1:0] e);
        acc(1'b0, RASM_SRC_CFG, ADDR_CTRL, 32'h0);
        acc(1'b1, RASM_SRC_CFG, ADDR_CTRL, (q & ~32'h1) | v);
        chk({31'h0, v}, {31'h0, unlockOut});
        acc(1'b1, RASM_SRC_CFG, ADDR_CELL, d);
        acc(1'b0, RASM_SRC_SMB, ADDR_CELL, 32'h0);
        chk(e, (q >> LOCK_LSB) & 32'h3);
        $display("test lock done");
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial
    begin
        mismatches   = 0;
        total_checks = 0;
        rst        = 1'b1;
        eepromDone = 1'b0;
        strapIn    = 4'h5;
        rdClrEvent   = 4'h0;
        rdClrWrEvent = 4'h0;
        w1cEvent   = 4'h0;
        statusIn   = 4'h0;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        t_reset();
        t_hardware_initialized();
        t_rdclr();
        t_w1c();
        t_fixed();
        t_lock(1'b1, 32'h20000000, 32'h2);
        t_lock(1'b0, 32'h10000000, 32'h2);
        give_verdict();
    end
endmodule
